// [pkg/spmc_pkg.sv]
package spmc_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] SPMC_OFF_STATUS = 8'h00;
	localparam logic [7:0] SPMC_OFF_CTRL = 8'h04;
	localparam logic [7:0] SPMC_OFF_WDT = 8'h08;
	localparam logic [7:0] SPMC_OFF_INT_STAT = 8'h0c;
	localparam logic [7:0] SPMC_OFF_INT_MASK = 8'h10;
	localparam logic [7:0] SPMC_OFF_PIN_IRQ = 8'h14;
	localparam logic [7:0] SPMC_OFF_KICK = 8'h18;
	// Control field positions
	localparam int SPMC_CTRL_BOOT_DONE = 0;
	localparam int SPMC_CTRL_RT_DONE = 1;
	localparam int SPMC_CTRL_MODE_LSB = 2;
	localparam int SPMC_CTRL_SWRST = 4;
	// Interrupt status bit positions
	localparam int SPMC_EV_WAKE = 0;
	localparam int SPMC_EV_WDT = 1;
	localparam int SPMC_EV_PINREJ = 2;
	localparam int SPMC_EV_N = 3;
	// Reset values
	localparam logic [15:0] SPMC_WDT_RST = 16'h03e8;
	localparam logic [31:0] SPMC_PIN_IRQ_RST = 32'h0000_0000;
	// Watchdog timing
	localparam int SPMC_CLK_HZ = 25_000_000;
	localparam int SPMC_WDT_MIN_MS = 1;
	localparam int SPMC_WDT_MAX_MS = 32768;
	localparam int SPMC_TICK_NS = 1_000_000;
	localparam int SPMC_CYC_PER_MS = SPMC_CLK_HZ / 1000;
	// Interrupt pin limits
	localparam int SPMC_MAX_IRQ_PINS = 16;
	localparam int SPMC_GPIO_N = 49;
	// Power modes
	typedef enum logic [1:0] {
		SPMC_PM_RUN, SPMC_PM_SLEEP, SPMC_PM_DEEP, SPMC_PM_OFF
	} spmc_pm_t;
endpackage : spmc_pkg

// [hdl/spmc_wdt.sv]
`timescale 1ns/1ps
module spmc_wdt
	import spmc_pkg::*;
#(
	parameter int CYC_PER_MS = SPMC_CYC_PER_MS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic enable_in,
	input wire logic kick_in,
	input wire logic [15:0] timeout_ms_in,
	// Expiry
	output logic expire_out
);
	typedef struct packed {
		logic [24:0] cyc;
		logic [15:0] ms;
		logic exp;
	} spmc_wdt_st_t;
	spmc_wdt_st_t st_r, st_nxt;
	logic [15:0] lim;

	// Zero reads as the 1 ms floor; limit is the ms field minus one, with no clamp at 32768
	assign lim = (timeout_ms_in == 16'h0000) ? 16'h0000 :
		timeout_ms_in - 16'h0001;

	// Millisecond prescaler then millisecond count
	always_comb begin
		st_nxt = st_r;
		st_nxt.exp = 1'b0;
		if (!enable_in || kick_in) begin
			st_nxt.cyc = '0;
			st_nxt.ms = '0;
		end else if (st_r.cyc == 25'(CYC_PER_MS - 1)) begin
			st_nxt.cyc = '0;
			if (st_r.ms >= lim) begin
				st_nxt.ms = '0;
				st_nxt.exp = 1'b1;
			end else begin
				st_nxt.ms = st_r.ms + 16'h0001;
			end
		end else begin
			st_nxt.cyc = st_r.cyc + 25'h0000001;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire_out = st_r.exp;

	a_wdt_pulse_one: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) expire_out |=> !expire_out)
		else $error("watchdog expiry longer than one cycle");
endmodule : spmc_wdt

// [hdl/spmc_top.sv]
`timescale 1ns/1ps
module spmc_top
	import spmc_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// Strap pins
	input wire logic BOOT_WAIT_STRAP_IN,
	input wire logic RESERVED_LOADER_STRAP_IN,
	input wire logic LINK_SEL_STRAP_IN,
	// Wake sources
	input wire logic RTC_ALARM_IN,
	input wire logic [SPMC_GPIO_N-1:0] GPIO_IRQ_IN,
	// Register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [31:0] REG_RDATA_OUT,
	// Pin defaults for the strap pins
	output logic [2:0] STRAP_PULLUP_EN_OUT,
	output logic [2:0] STRAP_OE_OUT,
	output logic STRAP_ROLE_OUT,
	// System control
	output logic SYS_RST_N_OUT,
	output logic BOOT_STAGE_OUT,
	output logic RUNTIME_STAGE_OUT,
	output logic APP_RUN_OUT,
	output logic BOOT_WAIT_OUT,
	output logic LINK_USB_OUT,
	output logic CPU_RUN_OUT,
	output logic FUNC_EN_OUT,
	output logic CORE_PWR_EN_OUT,
	output logic [1:0] PWR_MODE_OUT,
	output logic [31:0] PIN_IRQ_EN_OUT,
	output logic IRQ_OUT
);
	typedef enum logic [2:0] {
		SPMC_S_SAMPLE, SPMC_S_BOOT, SPMC_S_WAIT, SPMC_S_RUNTIME, SPMC_S_APP
	} spmc_seq_t;

	typedef struct packed {
		spmc_seq_t seq;
		logic boot_wait;
		logic link_usb;
		logic rst_req;
		spmc_pm_t pm;
		logic [15:0] wdt_ms;
		logic wdt_en;
		logic [31:0] pin_irq;
		logic [SPMC_EV_N-1:0] int_stat;
		logic [SPMC_EV_N-1:0] int_mask;
		logic [31:0] rdata;
	} spmc_st_t;

	spmc_st_t st_r, st_nxt;
	logic wdt_exp;
	logic wake;
	logic [5:0] irq_cnt;
	logic irq_ok;
	logic [SPMC_EV_N-1:0] ev;

	// Count set bits; used for the pin interrupt enable limit
	function automatic logic [5:0] spmc_popcnt(input logic [31:0] v);
		logic [5:0] n;
		n = '0;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, v[i]};
		end
		return n;
	endfunction : spmc_popcnt

	// Bits 15:0 are port A indices, 31:16 port B; one index per pin
	// number, so a shared index is refused instead of stored.
	assign irq_cnt = spmc_popcnt(REG_WDATA_IN);
	assign irq_ok = (irq_cnt <= 6'(SPMC_MAX_IRQ_PINS)) &&
		((REG_WDATA_IN[15:0] & REG_WDATA_IN[31:16]) == 16'h0000);

	// Wake on alarm or any enabled pin interrupt
	assign wake = RTC_ALARM_IN || (|(GPIO_IRQ_IN[31:0] & st_r.pin_irq));

	spmc_wdt u_wdt (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(SYS_RST_N_OUT),
		.enable_in(st_r.wdt_en && st_r.pm == SPMC_PM_RUN),
		.kick_in(REG_WR_IN && REG_ADDR_IN == SPMC_OFF_KICK),
		.timeout_ms_in(st_r.wdt_ms),
		.expire_out(wdt_exp)
	);

	// Next state: sequencer, power modes, registers
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		ev = '0;
		case (st_r.seq)
			SPMC_S_SAMPLE: begin
				// Straps taken once after release, held after
				st_nxt.boot_wait = !BOOT_WAIT_STRAP_IN;
				st_nxt.link_usb = LINK_SEL_STRAP_IN;
				st_nxt.seq = SPMC_S_BOOT;
			end
			SPMC_S_BOOT: begin
				if (REG_WR_IN && REG_ADDR_IN == SPMC_OFF_CTRL &&
					REG_WDATA_IN[SPMC_CTRL_BOOT_DONE]) begin
					st_nxt.seq = st_r.boot_wait ? SPMC_S_WAIT :
						SPMC_S_RUNTIME;
				end
			end
			SPMC_S_WAIT: st_nxt.seq = SPMC_S_WAIT;
			SPMC_S_RUNTIME: begin
				if (REG_WR_IN && REG_ADDR_IN == SPMC_OFF_CTRL &&
					REG_WDATA_IN[SPMC_CTRL_RT_DONE]) begin
					st_nxt.seq = SPMC_S_APP;
				end
			end
			SPMC_S_APP: st_nxt.seq = SPMC_S_APP;
			default: st_nxt.seq = SPMC_S_SAMPLE;
		endcase

		// Power mode entries and exits
		case (st_r.pm)
			SPMC_PM_SLEEP, SPMC_PM_DEEP: begin
				if (wake) begin
					st_nxt.pm = SPMC_PM_RUN;
					ev[SPMC_EV_WAKE] = 1'b1;
				end
			end
			SPMC_PM_OFF: begin
				// Only the alarm or a CTRL soft reset write leaves off, and both force reset
				if (RTC_ALARM_IN) begin
					st_nxt.rst_req = 1'b1;
				end
			end
			SPMC_PM_RUN: begin
				if (REG_WR_IN && REG_ADDR_IN == SPMC_OFF_CTRL) begin
					st_nxt.pm = spmc_pm_t'(
						REG_WDATA_IN[SPMC_CTRL_MODE_LSB +: 2]);
				end
			end
			default: st_nxt.pm = SPMC_PM_RUN;
		endcase

		// Register writes
		if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				SPMC_OFF_CTRL: begin
					if (REG_WDATA_IN[SPMC_CTRL_SWRST]) begin
						st_nxt.rst_req = 1'b1;
					end
				end
				SPMC_OFF_WDT: begin
					st_nxt.wdt_ms = REG_WDATA_IN[15:0];
					st_nxt.wdt_en = REG_WDATA_IN[31];
				end
				SPMC_OFF_INT_STAT: begin
					st_nxt.int_stat = st_r.int_stat &
						~REG_WDATA_IN[SPMC_EV_N-1:0];
				end
				SPMC_OFF_INT_MASK: begin
					st_nxt.int_mask = REG_WDATA_IN[SPMC_EV_N-1:0];
				end
				SPMC_OFF_PIN_IRQ: begin
					if (irq_ok) begin
						st_nxt.pin_irq = REG_WDATA_IN;
					end else begin
						ev[SPMC_EV_PINREJ] = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Watchdog expiry requests full reset
		if (wdt_exp) begin
			st_nxt.rst_req = 1'b1;
			ev[SPMC_EV_WDT] = 1'b1;
		end
		// Set wins over a same-cycle clear
		st_nxt.int_stat = st_nxt.int_stat | ev;

		// Register reads, data in the following cycle
		if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				SPMC_OFF_STATUS: st_nxt.rdata = {25'h0000000,
					st_r.pm, st_r.seq, st_r.link_usb, st_r.boot_wait};
				SPMC_OFF_CTRL: st_nxt.rdata = {28'h0000000, st_r.pm, 2'b00};
				SPMC_OFF_WDT: st_nxt.rdata = {st_r.wdt_en, 15'h0000,
					st_r.wdt_ms};
				SPMC_OFF_INT_STAT: st_nxt.rdata = 32'(st_r.int_stat);
				SPMC_OFF_INT_MASK: st_nxt.rdata = 32'(st_r.int_mask);
				SPMC_OFF_PIN_IRQ: st_nxt.rdata = st_r.pin_irq;
				default: st_nxt.rdata = '0;
			endcase
		end
	end

	// State register; rst_req pulls our own system reset
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_r.seq <= SPMC_S_SAMPLE;
			st_r.boot_wait <= 1'b0;
			st_r.link_usb <= 1'b1;
			st_r.rst_req <= 1'b0;
			st_r.pm <= SPMC_PM_RUN;
			st_r.wdt_ms <= SPMC_WDT_RST;
			st_r.wdt_en <= 1'b0;
			st_r.pin_irq <= SPMC_PIN_IRQ_RST;
			st_r.int_stat <= '0;
			st_r.int_mask <= '0;
			st_r.rdata <= '0;
		end else if (st_r.rst_req) begin
			// Full system restart; status survives for software
			st_r <= '{seq: SPMC_S_SAMPLE, boot_wait: 1'b0, link_usb: 1'b1,
				rst_req: 1'b0, pm: SPMC_PM_RUN, wdt_ms: SPMC_WDT_RST,
				wdt_en: 1'b0, pin_irq: SPMC_PIN_IRQ_RST,
				int_stat: st_r.int_stat, int_mask: st_r.int_mask,
				rdata: 32'h00000000};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign SYS_RST_N_OUT = RST_N_IN && !st_r.rst_req;
	assign STRAP_ROLE_OUT = (st_r.seq == SPMC_S_SAMPLE);
	assign STRAP_OE_OUT = 3'b000;
	assign STRAP_PULLUP_EN_OUT = 3'b111;
	assign BOOT_STAGE_OUT = (st_r.seq == SPMC_S_BOOT) ||
		(st_r.seq == SPMC_S_WAIT);
	assign RUNTIME_STAGE_OUT = (st_r.seq == SPMC_S_RUNTIME);
	assign APP_RUN_OUT = (st_r.seq == SPMC_S_APP);
	assign BOOT_WAIT_OUT = st_r.boot_wait;
	assign LINK_USB_OUT = st_r.link_usb;
	assign CPU_RUN_OUT = (st_r.pm == SPMC_PM_RUN);
	assign FUNC_EN_OUT = (st_r.pm == SPMC_PM_RUN) ||
		(st_r.pm == SPMC_PM_SLEEP);
	assign CORE_PWR_EN_OUT = (st_r.pm != SPMC_PM_OFF);
	assign PWR_MODE_OUT = st_r.pm;
	assign PIN_IRQ_EN_OUT = st_r.pin_irq;
	assign REG_RDATA_OUT = st_r.rdata;
	assign IRQ_OUT = |(st_r.int_stat & st_r.int_mask);

	// Off exit: one cycle of system reset, then the strap sample cycle
	sequence s_off_restart;
		!SYS_RST_N_OUT ##1 STRAP_ROLE_OUT;
	endsequence

	a_strap_boot_wait: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.seq == SPMC_S_SAMPLE && !st_r.rst_req)
		|=> BOOT_WAIT_OUT == !$past(BOOT_WAIT_STRAP_IN))
		else $error("boot wait strap not captured");
	a_strap_link_sel: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.seq == SPMC_S_SAMPLE && !st_r.rst_req)
		|=> LINK_USB_OUT == $past(LINK_SEL_STRAP_IN))
		else $error("link select strap not captured");
	a_strap_held: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.seq != SPMC_S_SAMPLE && !st_r.rst_req)
		|=> $stable(BOOT_WAIT_OUT) && $stable(LINK_USB_OUT))
		else $error("strap value changed after capture");
	a_wait_sticks: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.seq == SPMC_S_WAIT && !st_r.rst_req)
		|=> !APP_RUN_OUT)
		else $error("application ran while waiting");
	a_order_runtime: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) $rose(APP_RUN_OUT)
		|-> $past(RUNTIME_STAGE_OUT))
		else $error("application started before runtime");
	// Other masked events may also drive the interrupt, so check the bit
	a_sleep_wake: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) ((st_r.pm == SPMC_PM_SLEEP ||
		st_r.pm == SPMC_PM_DEEP) && wake && !st_r.rst_req)
		|=> CPU_RUN_OUT && st_r.int_stat[SPMC_EV_WAKE])
		else $error("sleep did not wake");
	// Alarm may still stand in the reset cycle; judge only the first one
	a_off_exit_reset: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN)
		(st_r.pm == SPMC_PM_OFF && RTC_ALARM_IN && !st_r.rst_req)
		|=> s_off_restart)
		else $error("off exit without system reset");
	a_off_gates_all: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.pm == SPMC_PM_OFF)
		|-> !FUNC_EN_OUT && !CPU_RUN_OUT && !CORE_PWR_EN_OUT)
		else $error("off mode left functions on");
	a_deep_gates: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) (st_r.pm == SPMC_PM_DEEP)
		|-> !FUNC_EN_OUT && !CPU_RUN_OUT)
		else $error("deep sleep left functions on");
	a_irq_pin_limit: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) spmc_popcnt(PIN_IRQ_EN_OUT) <=
		6'(SPMC_MAX_IRQ_PINS))
		else $error("more than sixteen interrupt pins");
	a_wdt_reset: assert property (@(posedge SYS_CLK_IN)
		disable iff (!RST_N_IN) wdt_exp |=> !SYS_RST_N_OUT)
		else $error("watchdog expiry did not reset");
	a_reset_holds: assert property (@(posedge SYS_CLK_IN)
		!RST_N_IN |-> !SYS_RST_N_OUT)
		else $error("reset not held");
endmodule : spmc_top

// [tb/spmc_board.sv]
`timescale 1ns/1ps
module spmc_board (
	// Bench controls
	input wire logic rst_hold_in,
	input wire logic [2:0] drv_en_in,
	input wire logic [2:0] drv_val_in,
	// Board nets
	output logic rst_n_out,
	output logic [2:0] strap_out
);
	// Reset pin floats, so the board carries its own pull-up
	assign rst_n_out = rst_hold_in ? 1'b0 : 1'b1;
	// Released straps rest at the pull-up level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			strap_out[i] = drv_en_in[i] ? drv_val_in[i] : 1'b1;
		end
	end
endmodule : spmc_board

// [tb/spmc_tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module spmc_tb_top;
	import spmc_pkg::*;
	// Bench drive
	logic clk = 1'b0;
	logic rst_hold = 1'b1;
	logic [2:0] drv_en = 3'h0;
	logic [2:0] drv_val = 3'h0;
	logic rtc = 1'b0;
	logic [48:0] gpio = 49'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	// Board and design nets
	logic rst_n;
	logic [2:0] strap, pu, oe;
	logic [31:0] rdata, pen;
	logic role, srst, bst, rts, app, bw, lusb, cpu, fen, cpe, irq;
	logic [1:0] pm;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;

	spmc_board u_board (.rst_hold_in(rst_hold), .drv_en_in(drv_en),
		.drv_val_in(drv_val), .rst_n_out(rst_n), .strap_out(strap));
	spmc_top u_dut (
		.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
		.BOOT_WAIT_STRAP_IN(strap[0]), .RESERVED_LOADER_STRAP_IN(strap[1]),
		.LINK_SEL_STRAP_IN(strap[2]), .RTC_ALARM_IN(rtc), .GPIO_IRQ_IN(gpio),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .STRAP_PULLUP_EN_OUT(pu),
		.STRAP_OE_OUT(oe), .STRAP_ROLE_OUT(role), .SYS_RST_N_OUT(srst),
		.BOOT_STAGE_OUT(bst), .RUNTIME_STAGE_OUT(rts), .APP_RUN_OUT(app),
		.BOOT_WAIT_OUT(bw), .LINK_USB_OUT(lusb), .CPU_RUN_OUT(cpu),
		.FUNC_EN_OUT(fen), .CORE_PWR_EN_OUT(cpe), .PWR_MODE_OUT(pm),
		.PIN_IRQ_EN_OUT(pen), .IRQ_OUT(irq)
	);

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// Hang guard, well above the watchdog wait
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end

	// Sample point just after the edge
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata & m, e)
	endtask : chk_reg

	// Bounded wait for the system reset pulse
	task automatic wait_rst(input int lim);
		n = 0;
		while (srst !== 1'b0 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_rst

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	// All-ones straps are left to the pull-ups; flipped once captured
	task automatic boot(input logic [2:0] s);
		@(posedge clk);
		rst_hold <= 1'b1;
		drv_en <= {3{s != 3'h7}};
		drv_val <= s;
		tick(8);
		`CHK(srst, 1'b0)
		`CHK(role, 1'b1)
		@(posedge clk);
		rst_hold <= 1'b0;
		tick(3);
		@(posedge clk);
		drv_en <= 3'h7;
		drv_val <= ~s;
		tick(2);
		`CHK(bst, 1'b1)
		`CHK(role, 1'b0)
		`CHK(bw, ~s[0])
		`CHK(lusb, s[2])
	endtask : boot

	task automatic t_app;
		boot(3'h7);
		`CHK(pu, 3'h7)
		`CHK(oe, 3'h0)
		wr_reg(SPMC_OFF_CTRL, 32'h1);
		tick(1);
		`CHK(rts, 1'b1)
		wr_reg(SPMC_OFF_CTRL, 32'h2);
		tick(1);
		`CHK(app, 1'b1)
		chk_reg(SPMC_OFF_STATUS, 32'h7f, 32'h12);
		`CHK(cpe, 1'b1)
		done("app");
	endtask : t_app

	task automatic t_pins;
		chk_reg(SPMC_OFF_WDT, 32'hffff_ffff, {16'h0, SPMC_WDT_RST});
		wr_reg(SPMC_OFF_PIN_IRQ, 32'h0001_ffff);
		tick(1);
		`CHK(pen, SPMC_PIN_IRQ_RST)
		chk_reg(SPMC_OFF_INT_STAT, 32'h4, 32'h4);
		wr_reg(SPMC_OFF_INT_STAT, 32'h4);
		wr_reg(SPMC_OFF_PIN_IRQ, 32'h0001_0001);
		tick(1);
		`CHK(pen, SPMC_PIN_IRQ_RST)
		chk_reg(SPMC_OFF_INT_STAT, 32'h4, 32'h4);
		wr_reg(SPMC_OFF_INT_STAT, 32'h4);
		wr_reg(SPMC_OFF_PIN_IRQ, 32'hffff_0000);
		tick(1);
		`CHK(pen, 32'hffff_0000)
		chk_reg(8'hfc, 32'hffff_ffff, 32'h0);
		chk_reg(SPMC_OFF_INT_STAT, 32'h7, 32'h0);
		done("pins");
	endtask : t_pins

	task automatic t_sleep;
		wr_reg(SPMC_OFF_INT_MASK, 32'h1);
		wr_reg(SPMC_OFF_CTRL, 32'h4);
		tick(1);
		`CHK(pm, SPMC_PM_SLEEP)
		`CHK(cpu, 1'b0)
		`CHK(fen, 1'b1)
		`CHK(irq, 1'b0)
		@(posedge clk);
		rtc <= 1'b1;
		@(posedge clk);
		rtc <= 1'b0;
		tick(3);
		`CHK(pm, SPMC_PM_RUN)
		`CHK(cpu, 1'b1)
		`CHK(irq, 1'b1)
		wr_reg(SPMC_OFF_INT_STAT, 32'h1);
		tick(1);
		`CHK(irq, 1'b0)
		done("sleep");
	endtask : t_sleep

	task automatic t_deep;
		wr_reg(SPMC_OFF_PIN_IRQ, 32'h8);
		wr_reg(SPMC_OFF_CTRL, 32'h8);
		tick(1);
		`CHK(pm, SPMC_PM_DEEP)
		`CHK(fen, 1'b0)
		`CHK(cpu, 1'b0)
		@(posedge clk);
		gpio <= 49'h20;
		tick(3);
		`CHK(pm, SPMC_PM_DEEP)
		@(posedge clk);
		gpio <= 49'h8;
		tick(3);
		`CHK(pm, SPMC_PM_RUN)
		@(posedge clk);
		gpio <= 49'h0;
		chk_reg(SPMC_OFF_INT_STAT, 32'h1, 32'h1);
		wr_reg(SPMC_OFF_INT_STAT, 32'h1);
		done("deep");
	endtask : t_deep

	task automatic t_off;
		wr_reg(SPMC_OFF_CTRL, 32'hc);
		tick(1);
		`CHK(pm, SPMC_PM_OFF)
		`CHK(cpe, 1'b0)
		`CHK(fen, 1'b0)
		@(posedge clk);
		gpio <= 49'h8;
		tick(3);
		`CHK(pm, SPMC_PM_OFF)
		`CHK(srst, 1'b1)
		@(posedge clk);
		gpio <= 49'h0;
		rtc <= 1'b1;
		wait_rst(10);
		`CHK(srst, 1'b0)
		@(posedge clk);
		rtc <= 1'b0;
		tick(4);
		`CHK(pm, SPMC_PM_RUN)
		`CHK(bst, 1'b1)
		done("off");
	endtask : t_off

	task automatic t_wait;
		boot(3'h0);
		wr_reg(SPMC_OFF_CTRL, 32'h1);
		tick(1);
		chk_reg(SPMC_OFF_STATUS, 32'h1f, 32'h9);
		wr_reg(SPMC_OFF_CTRL, 32'h2);
		tick(1);
		`CHK(app, 1'b0)
		`CHK(rts, 1'b0)
		// Reserved strap low, others high: normal start path expected
		boot(3'h5);
		wr_reg(SPMC_OFF_CTRL, 32'h1);
		tick(1);
		`CHK(rts, 1'b1)
		done("wait");
	endtask : t_wait

	// Kick mid-count, then expiry one full period after the kick
	task automatic t_wdt;
		wr_reg(SPMC_OFF_INT_STAT, 32'h7);
		wr_reg(SPMC_OFF_WDT, 32'h8000_0001);
		tick(20000);
		`CHK(srst, 1'b1)
		wr_reg(SPMC_OFF_KICK, 32'h0);
		wait_rst(30000);
		`CHK(n inside {[24990:25010]}, 1'b1)
		tick(2);
		chk_reg(SPMC_OFF_INT_STAT, 32'h2, 32'h2);
		done("watchdog");
	endtask : t_wdt

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		t_app();
		t_pins();
		t_sleep();
		t_deep();
		t_off();
		t_wait();
		t_wdt();
		end_of_test();
	end
endmodule : spmc_tb_top
